// ===== hw/cmp_pkg.sv
package cmp_pkg;
  // byte addresses are four times the printed register index
  localparam logic [11:0] IDX_CTRL1   = 12'h111;
  localparam logic [11:0] IDX_SEL1    = 12'h112;
  localparam logic [11:0] IDX_CTRL2   = 12'h113;
  localparam logic [11:0] IDX_SEL2    = 12'h114;
  localparam logic [11:0] IDX_MIRROR  = 12'h115;
  localparam logic [11:0] IDX_FLAGS   = 12'h120;
  localparam logic [11:0] IDX_IRQMASK = 12'h121;

  localparam logic [7:0] CTRL_RESET   = 8'h04;
  localparam logic [7:0] SEL_RESET    = 8'h00;
  localparam logic [7:0] CTRL_WMASK   = 8'h97;
  localparam int         CTRL_RES_POS = 6;
  localparam int         RISE_POS     = 7;
  localparam int         FALL_POS     = 6;
  localparam int         FLAG1_POS    = 5;
  localparam int         FLAG2_POS    = 6;

  typedef enum logic [1:0] {
    POS_PIN, POS_DAC, POS_RSVD, POS_GND
  } pos_route_t;

  typedef enum logic [2:0] {
    NEG_PIN0, NEG_PIN1, NEG_PIN2, NEG_PIN3, NEG_RSVD4, NEG_RSVD5, NEG_FVR, NEG_GND
  } neg_route_t;

  typedef struct packed {
    pos_route_t posRoute;
    neg_route_t negRoute;
    logic       negValid;
  } route_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } ahb_req_t;
endpackage : cmp_pkg

// ===== hw/comparator_select_irq.sv
`timescale 1ns/1ns
module comparator_select_irq (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire cmp_pkg::ahb_req_t ahbReq,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              compOneResult,
  input  wire logic              compTwoResult,
  output cmp_pkg::route_t        routeOne,
  output cmp_pkg::route_t        routeTwo,
  output logic                   compOneEnable,
  output logic                   compTwoEnable,
  output logic                   irq
);
  typedef struct packed {
    logic [7:0]      ctrl1;
    logic [7:0]      sel1;
    logic [7:0]      ctrl2;
    logic [7:0]      sel2;
    logic [1:0]      flags;
    logic [1:0]      irqMask;
    logic [1:0]      syncA;
    logic [1:0]      syncB;
    logic [1:0]      prev;
    logic            wrPend;
    logic [11:0]     wrIdx;
    logic [31:0]     rdata;
    logic            irqOut;
    cmp_pkg::route_t rOne;
    cmp_pkg::route_t rTwo;
  } state_t;

  state_t cur;
  state_t next_cur;

  function automatic cmp_pkg::route_t decodeSel(input logic [7:0] sel);
    cmp_pkg::route_t r;
    r.posRoute = cmp_pkg::pos_route_t'(sel[5:4]);
    r.negRoute = cmp_pkg::neg_route_t'(sel[2:0]);
    r.negValid = (sel[2:0] != 3'h4) && (sel[2:0] != 3'h5);
    return r;
  endfunction : decodeSel

  function automatic logic edgeHit(input logic [7:0] sel, input logic now, input logic was);
    return (sel[cmp_pkg::RISE_POS] && now && !was) || (sel[cmp_pkg::FALL_POS] && !now && was);
  endfunction : edgeHit

  function automatic logic [7:0] readCtrl(input logic [7:0] ctrl, input logic res);
    logic [7:0] v;
    v = ctrl & cmp_pkg::CTRL_WMASK;
    v[cmp_pkg::CTRL_RES_POS] = res;
    return v;
  endfunction : readCtrl

  logic        addrTake;
  logic [11:0] rdIdx;
  logic [1:0]  events;
  logic [1:0]  wrClear;
  logic [7:0]  wbyte;
  logic [7:0]  rbyte;

  always_comb begin
    next_cur = cur;
    addrTake = ahbReq.hsel && ahbReq.hready && ahbReq.htrans[1];
    rdIdx = ahbReq.haddr[13:2];
    wbyte = ahbReq.hwdata[7:0];
    wrClear = 2'h0;
    // comparator outputs come from analog cores: two-stage synchroniser
    next_cur.syncA = {cur.syncA[0], compOneResult};
    next_cur.syncB = {cur.syncB[0], compTwoResult};
    next_cur.prev = {cur.syncB[1], cur.syncA[1]};
    events[0] = edgeHit(cur.sel1, cur.syncA[1], cur.prev[0]);
    events[1] = edgeHit(cur.sel2, cur.syncB[1], cur.prev[1]);
    if (cur.wrPend) begin
      case (cur.wrIdx)
        cmp_pkg::IDX_CTRL1: next_cur.ctrl1 = wbyte & cmp_pkg::CTRL_WMASK;
        cmp_pkg::IDX_SEL1: next_cur.sel1 = wbyte & 8'hF7;
        cmp_pkg::IDX_CTRL2: next_cur.ctrl2 = wbyte & cmp_pkg::CTRL_WMASK;
        cmp_pkg::IDX_SEL2: next_cur.sel2 = wbyte & 8'hF7;
        cmp_pkg::IDX_FLAGS: begin
          // writing zero clears a flag, as does writing one to hwdata bit 8 (flag 1) or bit 9 (flag 2)
          wrClear[0] = !wbyte[cmp_pkg::FLAG1_POS] || ahbReq.hwdata[8];
          wrClear[1] = !wbyte[cmp_pkg::FLAG2_POS] || ahbReq.hwdata[9];
        end
        cmp_pkg::IDX_IRQMASK: next_cur.irqMask = {wbyte[cmp_pkg::FLAG2_POS], wbyte[cmp_pkg::FLAG1_POS]};
        default: ;
      endcase
    end
    // set independent of mask; set wins over clear
    next_cur.flags = (cur.flags & ~wrClear) | events;
    next_cur.wrPend = addrTake && ahbReq.hwrite;
    next_cur.wrIdx = rdIdx;
    rbyte = 8'h00;
    case (rdIdx)
      cmp_pkg::IDX_CTRL1: rbyte = readCtrl(cur.ctrl1, cur.syncA[1]);
      cmp_pkg::IDX_SEL1: rbyte = cur.sel1;
      cmp_pkg::IDX_CTRL2: rbyte = readCtrl(cur.ctrl2, cur.syncB[1]);
      cmp_pkg::IDX_SEL2: rbyte = cur.sel2;
      cmp_pkg::IDX_MIRROR: rbyte = {6'h00, cur.syncB[1], cur.syncA[1]};
      cmp_pkg::IDX_FLAGS: rbyte = {1'b0, cur.flags[1], cur.flags[0], 5'h00};
      cmp_pkg::IDX_IRQMASK: rbyte = {1'b0, cur.irqMask[1], cur.irqMask[0], 5'h00};
      default: rbyte = 8'h00;
    endcase
    if (addrTake && !ahbReq.hwrite) begin
      next_cur.rdata = {24'h000000, rbyte};
    end
    next_cur.irqOut = |(next_cur.flags & cur.irqMask);
    next_cur.rOne = decodeSel(next_cur.sel1);
    next_cur.rTwo = decodeSel(next_cur.sel2);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur <= '0;
      cur.ctrl1 <= cmp_pkg::CTRL_RESET;
      cur.ctrl2 <= cmp_pkg::CTRL_RESET;
      cur.sel1 <= cmp_pkg::SEL_RESET;
      cur.sel2 <= cmp_pkg::SEL_RESET;
      // route outputs match the decode of the reset select value
      cur.rOne.negValid <= 1'b1;
      cur.rTwo.negValid <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign hrdata = cur.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign routeOne = cur.rOne;
  assign routeTwo = cur.rTwo;
  assign compOneEnable = cur.ctrl1[7];
  assign compTwoEnable = cur.ctrl2[7];
  assign irq = cur.irqOut;
endmodule : comparator_select_irq

// ===== tb/cmp_core_model.sv
`timescale 1ns/1ns
module cmp_core_model (
  input  wire logic       clk,
  input  wire logic [1:0] level,
  output logic      [1:0] result
);
  // slow analog core: output settles one cycle after the commanded level
  always_ff @(posedge clk) result <= level;
endmodule : cmp_core_model

// ===== tb/comparator_select_irq_asserts.sv
`timescale 1ns/1ns
module comparator_select_irq_asserts (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire cmp_pkg::ahb_req_t ahbReq,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic              compOneResult,
  input wire logic              compTwoResult,
  input wire cmp_pkg::route_t   routeOne,
  input wire cmp_pkg::route_t   routeTwo,
  input wire logic              compOneEnable,
  input wire logic              compTwoEnable,
  input wire logic              irq
);
  logic       go, wr, rdMir, rdFlg;
  logic [1:0] cmp;
  assign cmp = {compTwoResult, compOneResult};
  assign go = ahbReq.hsel && ahbReq.hready && ahbReq.htrans[1];
  assign wr = go && ahbReq.hwrite;
  assign rdMir = go && !ahbReq.hwrite && ahbReq.haddr == 32'h454;
  assign rdFlg = go && !ahbReq.hwrite && ahbReq.haddr == 32'h480;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_calm; $stable(cmp)[*4]; endsequence
  property p_neg1; routeOne.negValid != (routeOne.negRoute[2:1] == 2'h2); endproperty
  a_neg1: assert property (p_neg1) else $error("route one validity");
  property p_neg2; routeTwo.negValid != (routeTwo.negRoute[2:1] == 2'h2); endproperty
  a_neg2: assert property (p_neg2) else $error("route two validity");
  property p_mirHi; rdMir |=> hrdata[31:2] == 30'h0; endproperty
  a_mirHi: assert property (p_mirHi) else $error("mirror upper bits");
  property p_mir; s_calm ##0 $past(rdMir) |-> hrdata[1:0] == cmp; endproperty
  a_mir: assert property (p_mir) else $error("mirror copy");
  property p_flgHi; rdFlg |=> (hrdata & 32'hFFFFFF9F) == 32'h0; endproperty
  a_flgHi: assert property (p_flgHi) else $error("flag spare bits");
  property p_hold; irq && !wr && !$past(wr) |=> irq; endproperty
  a_hold: assert property (p_hold) else $error("irq dropped");
  property p_route; !$stable({routeOne, routeTwo}) |-> $past(wr) || $past(wr, 2) || $past(wr, 3); endproperty
  a_route: assert property (p_route) else $error("route moved");
  property p_cause; $rose(irq) |-> $past(wr, 2) || $past(wr, 3) || $past(cmp, 5) != $past(cmp); endproperty
  a_cause: assert property (p_cause) else $error("irq without cause");
endmodule : comparator_select_irq_asserts
bind comparator_select_irq comparator_select_irq_asserts u_chk (.*);

// ===== tb/comparator_select_irq_bench.sv
`timescale 1ns/1ns
`define CHK(a, e) begin checkCount++; if ((a) !== (e)) begin numErrors++; $display("[ERR] %0t %h %h", $time, a, e); end end
module comparator_select_irq_bench;
  logic              clk = 0, rst_n = 0, irq, rdy;
  logic [1:0]        level = 2'h0, res;
  logic [31:0]       hrdata, rd;
  cmp_pkg::ahb_req_t bus = '{hready: 1'h1, default: '0};
  cmp_pkg::route_t   r1, r2;
  int                numErrors = 0, checkCount = 0, cycles = 0;
  always #50 clk = ~clk;
  cmp_core_model u_core (.clk(clk), .level(level), .result(res));
  comparator_select_irq u_dut (.clk(clk), .rst_n(rst_n), .ahbReq(bus), .hrdata(hrdata), .hreadyout(rdy),
    .hresp(), .compOneResult(res[0]), .compTwoResult(res[1]), .routeOne(r1), .routeTwo(r2),
    .compOneEnable(), .compTwoEnable(), .irq(irq));
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    bus <= '{hsel: 1'h1, haddr: a, htrans: 2'h2, hwrite: w, hsize: 3'h2, hready: 1'h1, hwdata: bus.hwdata};
    do @(posedge clk); while (!rdy);
    bus <= '{hready: 1'h1, hwdata: d, default: '0};
    do @(posedge clk); while (!rdy);
    rd = hrdata;
  endtask : xfer
  task automatic t_reset;
    for (int i = 0; i < 6; i++) begin
      xfer(32'h444 + 4 * i, 1'h0, 32'h0);
      `CHK(rd, i == 0 || i == 2 ? 32'h4 : 32'h0)
    end
    xfer(32'h480, 1'h0, 32'h0);
    `CHK(rd, 32'h0)
  endtask : t_reset
  task automatic t_route;
    for (int i = 0; i < 8; i++) begin
      xfer(32'h448, 1'h1, {26'h0, i[1:0], 1'h0, i[2:0]});
      xfer(32'h450, 1'h1, {26'h0, i[1:0], 1'h0, i[2:0]});
      repeat (2) @(posedge clk);
      `CHK({r1, r2}, {2{i[1:0], i[2:0], i[2:1] != 2'h2}})
    end
  endtask : t_route
  task automatic t_edge;
    xfer(32'h480, 1'h1, 32'h0);
    xfer(32'h448, 1'h1, 32'h80);
    xfer(32'h450, 1'h1, 32'h40);
    level <= 2'h3;
    repeat (6) @(posedge clk);
    xfer(32'h480, 1'h0, 32'h0);
    `CHK({rd, irq}, {32'h20, 1'h0})
    xfer(32'h454, 1'h0, 32'h0);
    `CHK(rd, 32'h3)
    xfer(32'h484, 1'h1, 32'h60);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'h1)
    xfer(32'h480, 1'h1, 32'h0);
    level <= 2'h0;
    repeat (6) @(posedge clk);
    xfer(32'h480, 1'h0, 32'h0);
    `CHK({rd, irq}, {32'h40, 1'h1})
  endtask : t_edge
  task automatic close_out;
    $display("errors %0d checks %0d", numErrors, checkCount);
    if (numErrors == 0 && checkCount > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    t_reset;
    t_route;
    t_edge;
    close_out;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      numErrors++;
      close_out;
    end
  end
endmodule : comparator_select_irq_bench
